// ### verilog/ffps_top.sv
`timescale 1ns/1ps
module ffps_top
  import ffps_pkg::*;
#(
  parameter int unsigned OVL_CYC = ffps_pkg::OVL_CYC_DEF,
  parameter int unsigned OFF_CYC = ffps_pkg::OFF_CYC_DEF,
  parameter int unsigned SS_CYC = ffps_pkg::SS_CYC_DEF
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // comparators
  input wire logic cmp_upper_fault,
  input wire logic cmp_lower_fault,
  input wire logic vcc_above_min,
  input wire logic vcc_above_on,
  input wire logic brown_out_ok,
  input wire logic overload_flag,
  input wire logic fb_above_fold,
  input wire logic fb_above_fold_margin,
  input wire logic drive_clk_pulse,
  // options
  input wire logic fault_auto_recover,
  // outputs
  output logic gate_drive_en,
  output logic startup_src_en,
  output logic overtemp_pullup_en,
  output logic overtemp_pullup_double,
  output logic over_power_offset_en,
  output logic over_power_offset_ramp,
  output logic soft_start_active,
  output logic latched_off
);
  import ffps_pkg::*;

  // ==========================================
  // fault pin qualification
  logic [BW-1:0] ov_cnt_q, ov_cnt_d, ot_cnt_q, ot_cnt_d;
  logic ev_seen_q, ev_seen_d;
  logic [2:0] evt_q, evt_d;
  logic ov_valid, ot_valid, pin_fault;
  ffps_state_t st_q, st_d;
  logic [TW-1:0] ovl_q, ovl_d, off_q, off_d, ss_q, ss_d;
  logic off_run_q, off_run_d;
  logic on_prev_q, bo_prev_q;
  logic on_rise, bo_rise;
  logic drv_q, src_q, pu_q, pud_q, opo_q, opr_q, ss_act_q, lat_q;
  logic drv_d, src_d, pu_d, pud_d, opo_d, opr_d, ss_act_d, lat_d;

  assign on_rise = vcc_above_on && !on_prev_q;
  assign bo_rise = brown_out_ok && !bo_prev_q;
  assign ov_valid = cmp_upper_fault && (ov_cnt_q == BLANK_CNT);
  // low comparator ignored in soft-start: pin capacitor still charging
  assign ot_valid = cmp_lower_fault &&
                    (ot_cnt_q == BLANK_CNT) && (st_q != FFPS_SOFT);

  always_comb begin
    ov_cnt_d = cmp_upper_fault ? ov_cnt_q : '0;
    if (cmp_upper_fault && ov_cnt_q != BLANK_CNT) begin
      ov_cnt_d = ov_cnt_q + BW'(1);
    end
    ot_cnt_d = cmp_lower_fault ? ot_cnt_q : '0;
    if (cmp_lower_fault && ot_cnt_q != BLANK_CNT) begin
      ot_cnt_d = ot_cnt_q + BW'(1);
    end
    ev_seen_d = ev_seen_q || ov_valid || ot_valid;
    evt_d = evt_q;
    pin_fault = 1'b0;
    if (st_q != FFPS_SOFT && st_q != FFPS_RUN) begin
      evt_d = '0;
      ev_seen_d = 1'b0;
    end else if (drive_clk_pulse) begin
      ev_seen_d = 1'b0;
      if (ev_seen_q || ov_valid || ot_valid) begin
        evt_d = evt_q + 3'h1;
      end else begin
        evt_d = '0;
      end
    end
    if (evt_q == EVT_LATCH) begin
      pin_fault = 1'b1;
      evt_d = '0;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ov_cnt_q <= '0;
      ot_cnt_q <= '0;
      ev_seen_q <= 1'b0;
      evt_q <= '0;
    end else begin
      ov_cnt_q <= ov_cnt_d;
      ot_cnt_q <= ot_cnt_d;
      ev_seen_q <= ev_seen_d;
      evt_q <= evt_d;
    end
  end

  // ==========================================
  // sequencer
  always_comb begin
    st_d = st_q;
    ovl_d = '0;
    off_d = off_q;
    ss_d = ss_q;
    off_run_d = off_run_q;
    unique case (st_q)
      FFPS_WAIT: begin
        if (on_rise) begin
          st_d = FFPS_SOFT;
          ss_d = '0;
        end
      end
      FFPS_SOFT, FFPS_RUN: begin
        if (st_q == FFPS_SOFT) begin
          ss_d = ss_q + TW'(1);
          if (ss_q == TW'(SS_CYC - 1)) begin
            st_d = FFPS_RUN;
          end
        end
        if (overload_flag) begin
          ovl_d = ovl_q + TW'(1);
        end
        if (pin_fault && !fault_auto_recover) begin
          st_d = FFPS_LATCH;
        end else if (pin_fault || (overload_flag && ovl_q == TW'(OVL_CYC - 1))) begin
          st_d = FFPS_HICCUP;
          off_d = '0;
          off_run_d = 1'b1;
        end else if (!vcc_above_min) begin
          st_d = FFPS_WAIT;
        end
      end
      FFPS_HICCUP: begin
        // hiccup off timer runs to OFF_CYC, but ends early when the brown-out level rises
        if (off_run_q) begin
          off_d = off_q + TW'(1);
          if (off_q == TW'(OFF_CYC - 1)) begin
            off_run_d = 1'b0;
          end
        end
        if (bo_rise) begin
          off_run_d = 1'b0;
        end
        if (on_rise && !off_run_q) begin
          st_d = FFPS_SOFT;
          ss_d = '0;
        end
      end
      FFPS_LATCH: begin
        if (bo_rise) begin
          st_d = FFPS_WAIT;
        end
      end
      default: st_d = FFPS_WAIT;
    endcase
    drv_d = (st_d == FFPS_SOFT) || (st_d == FFPS_RUN);
    // source starts only below minimum, then charges up to turn-on;
    // the hysteresis keeps the supply cycling in latch and hiccup
    src_d = !drv_d && (src_q ? !vcc_above_on : !vcc_above_min);
    pu_d = vcc_above_min && drv_d;
    pud_d = pu_d && (st_d == FFPS_SOFT);
    opo_d = drv_d && fb_above_fold;
    opr_d = opo_d && !fb_above_fold_margin;
    ss_act_d = (st_d == FFPS_SOFT);
    lat_d = (st_d == FFPS_LATCH);
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= FFPS_WAIT;
      ovl_q <= '0;
      off_q <= '0;
      ss_q <= '0;
      off_run_q <= 1'b0;
      on_prev_q <= 1'b0;
      bo_prev_q <= 1'b0;
      drv_q <= 1'b0;
      src_q <= 1'b0;
      pu_q <= 1'b0;
      pud_q <= 1'b0;
      opo_q <= 1'b0;
      opr_q <= 1'b0;
      ss_act_q <= 1'b0;
      lat_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ovl_q <= ovl_d;
      off_q <= off_d;
      ss_q <= ss_d;
      off_run_q <= off_run_d;
      on_prev_q <= vcc_above_on;
      bo_prev_q <= brown_out_ok;
      drv_q <= drv_d;
      src_q <= src_d;
      pu_q <= pu_d;
      pud_q <= pud_d;
      opo_q <= opo_d;
      opr_q <= opr_d;
      ss_act_q <= ss_act_d;
      lat_q <= lat_d;
    end
  end

  assign gate_drive_en = drv_q;
  assign startup_src_en = src_q;
  assign overtemp_pullup_en = pu_q;
  assign overtemp_pullup_double = pud_q;
  assign over_power_offset_en = opo_q;
  assign over_power_offset_ramp = opr_q;
  assign soft_start_active = ss_act_q;
  assign latched_off = lat_q;

  // ==========================================
  // assertions
  a_latch_drive_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
    st_q == FFPS_LATCH |-> !gate_drive_en) else $error("drive on while latched");
  a_latch_holds: assert property (@(posedge clk_sys) disable iff (sys_rst)
    st_q == FFPS_LATCH && !bo_rise |=> st_q == FFPS_LATCH)
    else $error("latch cleared without brown-out");
  a_ot_ignored_ss: assert property (@(posedge clk_sys) disable iff (sys_rst)
    st_q == FFPS_SOFT |-> !ot_valid) else $error("low comparator used in soft-start");
  a_blank_short: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !cmp_upper_fault ##1 cmp_upper_fault |-> !ov_valid) else $error("unblanked over-voltage");
  a_pullup_min: assert property (@(posedge clk_sys) disable iff (sys_rst)
    overtemp_pullup_en |-> $past(vcc_above_min)) else $error("pull-up before minimum");
  a_double_ss: assert property (@(posedge clk_sys) disable iff (sys_rst)
    overtemp_pullup_double |-> soft_start_active) else $error("double current outside soft-start");
  a_src_below_min: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(startup_src_en) |-> !$past(vcc_above_min)) else $error("source on above minimum");
  a_src_to_on: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $fell(startup_src_en) && !gate_drive_en |-> $past(vcc_above_on))
    else $error("source stopped below turn-on");
  a_no_early_restart: assert property (@(posedge clk_sys) disable iff (sys_rst)
    st_q == FFPS_HICCUP && off_run_q && !bo_rise |=> st_q == FFPS_HICCUP)
    else $error("restart during off timer");
  a_opp_suppress: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !fb_above_fold |=> !over_power_offset_en) else $error("offset below foldback");
  a_opp_ramp: assert property (@(posedge clk_sys) disable iff (sys_rst)
    over_power_offset_ramp |-> over_power_offset_en) else $error("ramp without offset");

  // ==========================================
  // fault pin event counting
  a_evt_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
    st_q == FFPS_RUN && drive_clk_pulse && !ev_seen_q && !ov_valid && !ot_valid
    |=> evt_q == '0) else $error("counter kept after clean pulse");
  a_evt_latch: assert property (@(posedge clk_sys) disable iff (sys_rst)
    evt_q == EVT_LATCH && !fault_auto_recover |=> st_q == FFPS_LATCH)
    else $error("fourth event did not latch");
  a_pin_recover: assert property (@(posedge clk_sys) disable iff (sys_rst)
    evt_q == EVT_LATCH && fault_auto_recover |=> st_q == FFPS_HICCUP)
    else $error("recovery option ignored");
  a_latch_out: assert property (@(posedge clk_sys) disable iff (sys_rst)
    latched_off |-> !gate_drive_en) else $error("latched flag with drive on");

  // ==========================================
  // overload hiccup
  a_ovl_fault: assert property (@(posedge clk_sys) disable iff (sys_rst)
    st_q == FFPS_RUN && overload_flag && ovl_q == TW'(OVL_CYC - 1) && !pin_fault
    |=> st_q == FFPS_HICCUP) else $error("overload not acknowledged");
  a_hiccup_drive: assert property (@(posedge clk_sys) disable iff (sys_rst)
    st_q == FFPS_HICCUP |-> !gate_drive_en) else $error("drive on in hiccup");
  a_hiccup_bo: assert property (@(posedge clk_sys) disable iff (sys_rst)
    st_q == FFPS_HICCUP && off_run_q && off_q != TW'(OFF_CYC - 1) && !bo_rise
    |=> off_run_q) else $error("off timer cut short");
  a_bo_abort: assert property (@(posedge clk_sys) disable iff (sys_rst)
    st_q == FFPS_HICCUP && bo_rise |=> !off_run_q)
    else $error("brown-out recovery ignored");
  a_restart_soft: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(gate_drive_en) |-> soft_start_active) else $error("restart without soft-start");
  a_ss_bound: assert property (@(posedge clk_sys) disable iff (sys_rst)
    st_q == FFPS_SOFT |-> ss_q < TW'(SS_CYC)) else $error("soft-start overrun");

  // ==========================================
  // coverage
  c_hiccup: cover property (@(posedge clk_sys) st_q == FFPS_HICCUP ##1 st_q == FFPS_SOFT);
  c_latch: cover property (@(posedge clk_sys) st_q == FFPS_RUN ##1 st_q == FFPS_LATCH);
  c_bo_clear: cover property (@(posedge clk_sys) st_q == FFPS_LATCH ##1 st_q == FFPS_WAIT);
  c_bo_abort: cover property (@(posedge clk_sys) st_q == FFPS_HICCUP && off_run_q && bo_rise);
endmodule // ffps_top

// ### include/ffps_pkg.sv
package ffps_pkg;
  // ==========================================
  // timing
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CLK_NS = 1_000_000_000 / CLK_HZ;
  localparam int unsigned BLANK_NS = 600;
  localparam int unsigned BLANK_CYC = (BLANK_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned OVL_MS = 64;
  localparam int unsigned OVL_CYC_DEF = OVL_MS * (CLK_HZ / 1000);
  localparam int unsigned OFF_S = 1;
  localparam int unsigned OFF_CYC_DEF = OFF_S * CLK_HZ;
  localparam int unsigned SS_MS = 8;
  localparam int unsigned SS_CYC_DEF = SS_MS * (CLK_HZ / 1000);
  localparam int unsigned TW = 24;
  localparam int unsigned BW = 4;
  localparam logic [BW-1:0] BLANK_CNT = BW'(BLANK_CYC);
  localparam logic [2:0] EVT_LATCH = 3'h4;
  // ==========================================
  // states
  typedef enum logic [2:0] {
    FFPS_WAIT = 3'b000,
    FFPS_SOFT = 3'b001,
    FFPS_RUN = 3'b010,
    FFPS_HICCUP = 3'b011,
    FFPS_LATCH = 3'b100
  } ffps_state_t;
endpackage

// ### dv/ffps_stage.sv
`timescale 1ns/1ps
// ==========
// power stage: supply level and drive clock
module ffps_stage (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // controller side
  input wire logic gate_drive_en,
  input wire logic startup_src_en,
  input wire logic boot,
  // sensed levels
  output logic vcc_above_min,
  output logic vcc_above_on,
  output logic drive_clk_pulse
);
  int lvl;
  int ph;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      lvl <= 0;
      ph <= 0;
    end else begin
      // aux winding feeds the supply only while switching
      if (startup_src_en || gate_drive_en || boot) lvl <= (lvl < 24) ? lvl + 1 : lvl;
      else lvl <= (lvl > 0) ? lvl - 1 : 0;
      ph <= gate_drive_en ? (ph + 1) % 8 : 0;
    end
  end
  assign vcc_above_min = lvl >= 10;
  assign vcc_above_on = lvl >= 20;
  assign drive_clk_pulse = gate_drive_en && ph == 7;
endmodule // ffps_stage

// ### dv/ffps_top_test.sv
`timescale 1ns/1ps
module ffps_top_test;
  import ffps_pkg::*;
  localparam int SSC = 40;
  localparam int OVC = 20;
  localparam int OFC = 50;
  logic clk_sys, sys_rst, cmp_upper_fault, cmp_lower_fault, brown_out_ok, overload_flag;
  logic fb_above_fold, fb_above_fold_margin, fault_auto_recover, boot, vcc_above_min;
  logic vcc_above_on, drive_clk_pulse, gate_drive_en, startup_src_en, overtemp_pullup_en;
  logic overtemp_pullup_double, over_power_offset_en, over_power_offset_ramp;
  logic soft_start_active, latched_off;
  int n_fail, samples_checked, t;
  ffps_top #(.OVL_CYC(OVC), .OFF_CYC(OFC), .SS_CYC(SSC)) ffps_top_i (.clk_sys, .sys_rst,
    .cmp_upper_fault, .cmp_lower_fault, .vcc_above_min, .vcc_above_on, .brown_out_ok,
    .overload_flag, .fb_above_fold, .fb_above_fold_margin, .drive_clk_pulse,
    .fault_auto_recover, .gate_drive_en, .startup_src_en, .overtemp_pullup_en,
    .overtemp_pullup_double, .over_power_offset_en, .over_power_offset_ramp,
    .soft_start_active, .latched_off);
  ffps_stage ffps_stage_i (.clk_sys, .sys_rst, .gate_drive_en, .startup_src_en, .boot,
    .vcc_above_min, .vcc_above_on, .drive_clk_pulse);
  initial begin
    clk_sys = 0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic got, input logic exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  task automatic chkr(input int got, input int lo, input int hi, input string m);
    chk(got >= lo && got <= hi, 1'b1, m);
  endtask
  function automatic logic sel(input int k);
    case (k)
      0: return soft_start_active;
      1: return gate_drive_en;
      2: return latched_off;
      3: return drive_clk_pulse;
      default: return startup_src_en;
    endcase
  endfunction
  // bounded wait; also watches, while not latched off, that the source only starts below the minimum
  task automatic wait_for(input int k, input logic v, input int lim, output int n);
    logic was_min;
    logic was_src;
    n = 0;
    do begin
      was_min = vcc_above_min;
      was_src = startup_src_en;
      @(posedge clk_sys);
      #1;
      n++;
      if (!latched_off && !gate_drive_en && !was_src) chk(startup_src_en && was_min, 0, "src");
    end while (sel(k) !== v && n < lim);
    if (sel(k) !== v) begin
      n_fail++;
      $display("[FAIL] %0t wait timeout", $time);
      conclude();
    end
  endtask
  task automatic pulses(input int k);
    repeat (k) wait_for(3, 1, 20, t);
  endtask
  task automatic power_up;
    wait_for(0, 1, 200, t);
    cmp_lower_fault <= 1;
    chk(overtemp_pullup_double, 1, "double");
    chk(gate_drive_en, 1, "ss drive");
    wait_for(0, 0, SSC + 5, t);
    chkr(t, SSC - 1, SSC + 1, "ss length");
    chk(latched_off, 0, "low ignored");
    chk(overtemp_pullup_en, 1, "pullup on");
    @(posedge clk_sys);
    cmp_lower_fault <= 0;
    boot <= 0;
  endtask
  initial begin
    {cmp_upper_fault, cmp_lower_fault, overload_flag, fb_above_fold} = 0;
    {fb_above_fold_margin, fault_auto_recover} = 0;
    {brown_out_ok, boot, sys_rst} = 3'b111;
    n_fail = 0;
    samples_checked = 0;
    void'($urandom(240));
    repeat (6) @(posedge clk_sys);
    sys_rst <= 0;
    #1;
    chk(overtemp_pullup_en, 0, "pullup early");
    power_up();
    repeat (6) begin
      pulses(1);
      cmp_upper_fault <= 1;
      repeat ($urandom_range(5, 1)) @(posedge clk_sys);
      cmp_upper_fault <= 0;
    end
    chk(latched_off, 0, "short blip");
    repeat (2) begin
      pulses(1);
      cmp_upper_fault <= 1;
      pulses(3);
      cmp_upper_fault <= 0;
      pulses(1);
    end
    chk(latched_off, 0, "clean pulse");
    cmp_upper_fault <= 1;
    wait_for(2, 1, 60, t);
    chkr(t, 25, 45, "four events");
    chk(gate_drive_en, 0, "latched drive");
    cmp_upper_fault <= 0;
    repeat (3) wait_for(4, 1, 60, t);
    chk(latched_off, 1, "latch held");
    brown_out_ok <= 0;
    @(posedge clk_sys);
    boot <= 1;
    brown_out_ok <= 1;
    wait_for(2, 0, 5, t);
    power_up();
    for (int i = 0; i < 3; i++) begin
      fb_above_fold <= i > 0;
      fb_above_fold_margin <= i == 2;
      repeat (3) @(posedge clk_sys);
      #1;
      chk(over_power_offset_en, i > 0, "offset");
      chk(over_power_offset_ramp, i == 1, "ramp");
    end
    fb_above_fold <= 0;
    fb_above_fold_margin <= 0;
    overload_flag <= 1;
    wait_for(1, 0, OVC + 5, t);
    chkr(t, OVC, OVC + 3, "overload time");
    overload_flag <= 0;
    wait_for(0, 1, 300, t);
    chkr(t, OFC, OFC + 40, "off timer");
    wait_for(0, 0, SSC + 5, t);
    overload_flag <= 1;
    wait_for(1, 0, OVC + 5, t);
    overload_flag <= 0;
    brown_out_ok <= 0;
    repeat (4) @(posedge clk_sys);
    brown_out_ok <= 1;
    wait_for(0, 1, 300, t);
    chkr(t, 1, OFC - 1, "bo restart");
    wait_for(0, 0, SSC + 5, t);
    fault_auto_recover <= 1;
    cmp_lower_fault <= 1;
    wait_for(1, 0, 60, t);
    cmp_lower_fault <= 0;
    chk(latched_off, 0, "auto recover");
    wait_for(0, 1, 300, t);
    conclude();
  end
endmodule // ffps_top_test
